//--- rtl/sus_pkg.sv
package sus_pkg;

    // register byte offsets
    localparam logic [7:0] SUS_OFS_CTRL = 8'h00;
    localparam logic [7:0] SUS_OFS_STAT = 8'h04;
    localparam logic [7:0] SUS_OFS_DATA = 8'h08;
    localparam logic [7:0] SUS_OFS_BUF  = 8'h0C;
    localparam logic [7:0] SUS_OFS_PORT = 8'h10;
    localparam logic [7:0] SUS_OFS_DIR  = 8'h14;

    // control register bit positions
    localparam int unsigned SUS_CTRL_STROBE = 1;
    localparam int unsigned SUS_CTRL_TOGGLE = 0;

    // status register bit positions and counter field width
    localparam int unsigned SUS_STAT_SIF = 7;
    localparam int unsigned SUS_STAT_OIF = 6;
    localparam int unsigned SUS_STAT_DC  = 4;
    localparam int unsigned SUS_CNT_W    = 4;

    // values after reset, counter limit and counter step
    localparam logic [6:0] SUS_CTRL_RST = 7'h00;
    localparam logic [2:0] SUS_PINS_RST = 3'h0;
    localparam logic [3:0] SUS_CNT_RST  = 4'h0;
    localparam logic [3:0] SUS_CNT_MAX  = 4'hF;
    localparam logic [3:0] SUS_CNT_ONE  = 4'h1;

    typedef enum logic [1:0] {
        SUS_WM_OFF      = 2'h0,
        SUS_WM_THREE    = 2'h1,
        SUS_WM_TWO      = 2'h2,
        SUS_WM_TWO_HOLD = 2'h3
    } sus_wire_mode_t;

    typedef enum logic [1:0] {
        SUS_CS_SOFT    = 2'h0,
        SUS_CS_TIMER   = 2'h1,
        SUS_CS_EXT_POS = 2'h2,
        SUS_CS_EXT_NEG = 2'h3
    } sus_clk_src_t;

    // control register, bits 7..1 (strobe bit kept as select)
    typedef struct packed {
        logic           start_irq_enable;
        logic           overflow_irq_enable;
        sus_wire_mode_t wire_mode_sel;
        sus_clk_src_t   clock_source_sel;
        logic           clock_strobe_select;
    } sus_ctrl_t;

    // one bit per pin: clock pin, data pin, data-out pin
    typedef struct packed {
        logic clk;
        logic data;
        logic dout;
    } sus_pins_t;

endpackage

//--- rtl/sus_unit.sv
`timescale 1ns/1ps

module sus_unit #(
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              clock,               // system clock
    input  wire logic              rst,                 // synchronous reset
    input  wire logic              psel,                // apb select
    input  wire logic              penable,             // apb enable
    input  wire logic              pwrite,              // apb direction
    input  wire logic [7:0]        paddr,               // apb byte address
    input  wire logic [31:0]       pwdata,              // apb write data
    output logic      [31:0]       prdata,              // apb read data
    output logic                   pready,              // apb ready
    output logic                   pslverr,             // apb error
    input  wire logic              global_irq_enable,   // cpu global enable
    input  wire logic              timer_compare_match, // timer tick pulse
    input  wire sus_pkg::sus_pins_t pin_in,             // pin levels, async
    output sus_pkg::sus_pins_t     pin_out,             // pin output values
    output sus_pkg::sus_pins_t     pin_oe_n,            // low while driving
    output sus_pkg::sus_pins_t     pin_pullup,          // pull-up enables
    output logic                   overflow_irq,        // overflow request
    output logic                   start_irq            // start request
);
    import sus_pkg::*;

    // refuse widths the shift path cannot serve
    if (DATA_W < 2 || DATA_W > 32) begin : g_check
        $error("sus_unit: DATA_W must be 2 to 32");
    end

    localparam int unsigned MSB = DATA_W - 1;

    // register state
    sus_ctrl_t          ctrl_q;
    sus_ctrl_t          ctrl_d;
    sus_pins_t          port_q;
    sus_pins_t          port_d;
    sus_pins_t          dir_q;
    sus_pins_t          dir_d;
    logic [MSB:0]       shift_q;
    logic [MSB:0]       shift_d;
    logic [MSB:0]       buf_q;
    logic [MSB:0]       buf_d;
    logic [3:0]         cnt_q;
    logic [3:0]         cnt_d;
    logic               oif_q;
    logic               oif_d;
    logic               sif_q;
    logic               sif_d;
    logic               latch_q;
    logic               latch_d;
    logic [31:0]        prdata_q;
    logic [31:0]        prdata_d;
    logic               pslverr_q;
    logic               pslverr_d;

    // synchroniser state
    logic               data_s1_q;
    logic               data_s2_q;
    logic               data_s3_q;
    logic               clk_s1_q;
    logic               clk_s2_q;
    logic               clk_s3_q;

    // decoded strobes and events
    logic               setup;
    logic               wr;
    logic               rd_acc;
    logic               wr_ctrl;
    logic               wr_stat;
    logic               wr_data;
    logic               rd_buf;
    logic               mapped;
    sus_ctrl_t          wctrl;
    logic               soft_strobe;
    logic               tc_strobe;
    logic               ext_rise;
    logic               ext_fall;
    logic               ext_src;
    logic               start_seen;
    logic               two_wire;
    logic               shift_tick;
    logic               count_tick;
    logic               shift_bit;
    logic               ovf_event;
    logic               dout_bit;
    logic               scl_hold;
    logic               collision;
    logic [31:0]        rd_mux;

    // apb phase decode; writes act only at the access edge
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign rd_acc  = psel & penable & ~pwrite;
    assign wr_ctrl = wr & (paddr == SUS_OFS_CTRL);
    assign wr_stat = wr & (paddr == SUS_OFS_STAT);
    assign wr_data = wr & (paddr == SUS_OFS_DATA);
    assign rd_buf  = rd_acc & (paddr == SUS_OFS_BUF);
    assign mapped  = (paddr == SUS_OFS_CTRL) | (paddr == SUS_OFS_STAT) |
                     (paddr == SUS_OFS_DATA) | (paddr == SUS_OFS_BUF)  |
                     (paddr == SUS_OFS_PORT) | (paddr == SUS_OFS_DIR);
    assign wctrl   = sus_ctrl_t'(pwdata[7:1]);

    // clock and data pin inputs pass three flops in every wire mode
    always_ff @(posedge clock) begin
        if (rst) begin
            data_s1_q <= 1'b0;
            data_s2_q <= 1'b0;
            data_s3_q <= 1'b0;
            clk_s1_q  <= 1'b0;
            clk_s2_q  <= 1'b0;
            clk_s3_q  <= 1'b0;
        end else begin
            data_s1_q <= pin_in.data;
            data_s2_q <= data_s1_q;
            data_s3_q <= data_s2_q;
            clk_s1_q  <= pin_in.clk;
            clk_s2_q  <= clk_s1_q;
            clk_s3_q  <= clk_s2_q;
        end
    end

    // edge finding on the synchronised clock pin
    assign ext_rise   = clk_s2_q & ~clk_s3_q;
    assign ext_fall   = ~clk_s2_q & clk_s3_q;
    assign ext_src    = ctrl_q.clock_source_sel[1];
    assign two_wire   = ctrl_q.wire_mode_sel[1];
    // data falling while clock stays high marks a start
    assign start_seen = clk_s2_q & clk_s3_q & data_s3_q & ~data_s2_q;

    // the soft strobe uses the written source field so one write sets and strobes
    assign soft_strobe = wr_ctrl & pwdata[SUS_CTRL_STROBE] &
                         (wctrl.clock_source_sel == SUS_CS_SOFT);
    assign tc_strobe   = wr_ctrl & pwdata[SUS_CTRL_TOGGLE];

    // shift clock selection
    always_comb begin
        shift_tick = 1'b0;
        shift_bit  = data_s2_q;
        unique case (ctrl_q.clock_source_sel)
            SUS_CS_SOFT: begin
                shift_tick = 1'b0;
            end
            SUS_CS_TIMER: begin
                shift_tick = timer_compare_match;
            end
            SUS_CS_EXT_POS: begin
                shift_tick = ext_rise;
            end
            SUS_CS_EXT_NEG: begin
                shift_tick = ext_fall;
            end
        endcase
        if (soft_strobe) begin
            shift_tick = 1'b1;
            shift_bit  = data_s3_q;
        end
    end

    // counter clock selection
    always_comb begin
        count_tick = 1'b0;
        if (ctrl_q.clock_source_sel == SUS_CS_TIMER) begin
            count_tick = timer_compare_match;
        end else if (ext_src) begin
            if (ctrl_q.clock_strobe_select) begin
                count_tick = tc_strobe;
            end else begin
                count_tick = ext_rise | ext_fall;
            end
        end
        // strobe write that selects the soft source counts like it shifts
        if (soft_strobe) begin
            count_tick = 1'b1;
        end
    end

    // overflow only when the counter really wraps, not on a cpu write
    assign ovf_event = count_tick & ~wr_stat & (cnt_q == SUS_CNT_MAX);

    // datapath and flags next values; hardware set beats software clear
    always_comb begin
        ctrl_d  = ctrl_q;
        port_d  = port_q;
        dir_d   = dir_q;
        shift_d = shift_q;
        buf_d   = buf_q;
        cnt_d   = cnt_q;
        oif_d   = oif_q;
        sif_d   = sif_q;
        latch_d = latch_q;
        if (wr_ctrl) begin
            ctrl_d = wctrl;
        end
        if (wr & (paddr == SUS_OFS_PORT)) begin
            port_d = sus_pins_t'(pwdata[2:0]);
        end
        if (tc_strobe) begin
            port_d.clk = ~port_d.clk;
        end
        if (wr & (paddr == SUS_OFS_DIR)) begin
            dir_d = sus_pins_t'(pwdata[2:0]);
        end
        // a cpu write to the data register wins over a shift
        if (wr_data) begin
            shift_d = pwdata[MSB:0];
        end else if (shift_tick) begin
            shift_d = {shift_q[MSB-1:0], shift_bit};
        end
        if (wr_stat) begin
            cnt_d = pwdata[SUS_CNT_W-1:0];
        end else if (count_tick) begin
            cnt_d = cnt_q + SUS_CNT_ONE;
        end
        if (ovf_event) begin
            buf_d = shift_d;
        end
        if ((wr_stat & pwdata[SUS_STAT_OIF]) | rd_buf) begin
            oif_d = 1'b0;
        end
        if (ovf_event) begin
            oif_d = 1'b1;
        end
        if (wr_stat & pwdata[SUS_STAT_SIF]) begin
            sif_d = 1'b0;
        end
        // detector off in mode 00 and three-wire; edge flag instead
        if (two_wire & start_seen) begin
            sif_d = 1'b1;
        end else if (~two_wire & ext_src & ~ctrl_q.clock_strobe_select &
                     (ext_rise | ext_fall)) begin
            sif_d = 1'b1;
        end
        // latch moves on the edge opposite the sampling edge
        if (!ext_src) begin
            latch_d = shift_q[MSB];
        end else if ((ctrl_q.clock_source_sel == SUS_CS_EXT_POS) ? ext_fall : ext_rise) begin
            latch_d = shift_q[MSB];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q  <= sus_ctrl_t'(SUS_CTRL_RST);
            port_q  <= sus_pins_t'(SUS_PINS_RST);
            dir_q   <= sus_pins_t'(SUS_PINS_RST);
            shift_q <= '0;
            buf_q   <= '0;
            cnt_q   <= SUS_CNT_RST;
            oif_q   <= 1'b0;
            sif_q   <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            port_q  <= port_d;
            dir_q   <= dir_d;
            shift_q <= shift_d;
            buf_q   <= buf_d;
            cnt_q   <= cnt_d;
            oif_q   <= oif_d;
            sif_q   <= sif_d;
            latch_q <= latch_d;
        end
    end

    // transparent path for internal sources so a strobe shows at once
    assign dout_bit  = ext_src ? latch_q : shift_q[MSB];
    assign scl_hold  = (two_wire & sif_q) |
                       ((ctrl_q.wire_mode_sel == SUS_WM_TWO_HOLD) & oif_q);
    assign collision = two_wire & (shift_q[MSB] != data_s2_q);

    // pin drive per wire mode
    always_comb begin
        pin_out    = port_q;
        pin_oe_n   = ~dir_q;
        pin_pullup = ~dir_q & port_q;
        unique case (ctrl_q.wire_mode_sel)
            SUS_WM_OFF: begin
                pin_out = port_q;
            end
            SUS_WM_THREE: begin
                // data-in and clock pins stay on plain port control
                pin_out.dout = dout_bit;
            end
            SUS_WM_TWO, SUS_WM_TWO_HOLD: begin
                // open drain: only ever drive low, release otherwise
                pin_out.data    = 1'b0;
                pin_oe_n.data   = ~(dir_q.data & (~dout_bit | ~port_q.data));
                pin_out.clk     = 1'b0;
                pin_oe_n.clk    = ~(dir_q.clk & (~port_q.clk | scl_hold));
                pin_pullup.data = 1'b0;
                pin_pullup.clk  = 1'b0;
            end
        endcase
    end

    // pending flags fire as soon as both enables are one
    assign overflow_irq = oif_q & ctrl_q.overflow_irq_enable & global_irq_enable;
    assign start_irq    = sif_q & ctrl_q.start_irq_enable & global_irq_enable;

    // read mux; strobe bits always read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            SUS_OFS_CTRL: begin
                rd_mux[7:2] = ctrl_q[6:1];
            end
            SUS_OFS_STAT: begin
                rd_mux[SUS_STAT_SIF]    = sif_q;
                rd_mux[SUS_STAT_OIF]    = oif_q;
                rd_mux[SUS_STAT_DC]     = collision;
                rd_mux[SUS_CNT_W-1:0]   = cnt_q;
            end
            SUS_OFS_DATA: begin
                rd_mux[MSB:0] = shift_q;
            end
            SUS_OFS_BUF: begin
                rd_mux[MSB:0] = buf_q;
            end
            SUS_OFS_PORT: begin
                rd_mux[2:0] = port_q;
            end
            SUS_OFS_DIR: begin
                rd_mux[2:0] = dir_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // read data captured in setup so it comes from a flop with no wait state
    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d  = pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_d = ~mapped;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;
    assign pready  = 1'b1;

endmodule

//--- testbench/sus_unit_checker.sv
`timescale 1ns/1ps

module sus_unit_checker (
    input wire logic               clock,             // system clock
    input wire logic               rst,               // sync reset
    input wire logic               psel,              // apb select
    input wire logic               penable,           // apb enable
    input wire logic               pwrite,            // apb direction
    input wire logic [7:0]         paddr,             // apb address
    input wire logic [31:0]        pwdata,            // apb write data
    input wire logic [31:0]        prdata,            // apb read data
    input wire logic               pready,            // apb ready
    input wire logic               global_irq_enable, // cpu enable
    input wire sus_pkg::sus_pins_t pin_out,           // pin values
    input wire sus_pkg::sus_pins_t pin_oe_n,          // drive enables
    input wire sus_pkg::sus_pins_t pin_pullup,        // pull-ups
    input wire logic               overflow_irq       // overflow request
);
    import sus_pkg::*;

    logic [1:0] mode_q, mode_d;
    logic [2:0] port_q, port_d;
    logic [2:0] dir_q, dir_d;
    logic       oie_q, oie_d;
    logic       wr;
    logic       ctl;

    // shadow of the bits that steer the pins, taken from bus writes
    assign wr  = psel && penable && pwrite && pready;
    assign ctl = wr && paddr == SUS_OFS_CTRL;

    // toggle strobe flips the shadow too, so plain-port checks stay exact
    always_comb begin
        mode_d = ctl ? pwdata[5:4] : mode_q;
        oie_d  = ctl ? pwdata[6] : oie_q;
        dir_d  = (wr && paddr == SUS_OFS_DIR) ? pwdata[2:0] : dir_q;
        port_d = (wr && paddr == SUS_OFS_PORT) ? pwdata[2:0] : port_q;
        if (ctl && pwdata[0]) begin
            port_d[2] = ~port_q[2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            {mode_q, oie_q, dir_q, port_q} <= 9'h000;
        end else begin
            {mode_q, oie_q, dir_q, port_q} <= {mode_d, oie_d, dir_d, port_d};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_irq_gate: assert property (overflow_irq |-> global_irq_enable && oie_q)
        else $error("overflow request with an enable off");
    a_off_plain: assert property (mode_q == 2'h0 |-> pin_out == port_q
        && pin_oe_n == ~dir_q && pin_pullup == (~dir_q & port_q))
        else $error("mode off pins not plain port");
    a_three_dout: assert property (mode_q == 2'h1 |-> pin_oe_n.dout == !dir_q[0]
        && pin_pullup.dout == (!dir_q[0] && port_q[0]))
        else $error("three-wire data-out drive or pull-up wrong");
    a_three_plain: assert property (mode_q == 2'h1 |->
        {pin_out.clk, pin_out.data} == port_q[2:1] && {pin_oe_n.clk, pin_oe_n.data} == ~dir_q[2:1])
        else $error("three-wire clock or data pin not plain port");
    a_two_release: assert property (mode_q[1] |->
        (dir_q[1] || pin_oe_n.data) && (dir_q[2] || pin_oe_n.clk))
        else $error("two-wire pin driven with direction off");
    a_two_sda_low: assert property (mode_q[1] && dir_q[1] && !port_q[1] |->
        !pin_oe_n.data && !pin_out.data)
        else $error("two-wire data not pulled low");
    a_two_scl_low: assert property (mode_q[1] && dir_q[2] && !port_q[2] |->
        !pin_oe_n.clk && !pin_out.clk)
        else $error("two-wire clock not pulled low");
    a_two_pullup: assert property (mode_q[1] |-> !pin_pullup.data && !pin_pullup.clk)
        else $error("two-wire pull-up left on");
    a_strobe_zero: assert property (psel && penable && !pwrite
        && paddr == SUS_OFS_CTRL |-> prdata[1:0] == 2'h0)
        else $error("strobe bits read nonzero");
    a_toggle_flip: assert property (ctl && pwdata[0] && mode_q == 2'h0
        && pwdata[5:4] == 2'h0 |=> pin_out.clk != $past(pin_out.clk))
        else $error("toggle strobe left clock pin unchanged");
endmodule

bind sus_unit sus_unit_checker i_chk (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .global_irq_enable, .pin_out, .pin_oe_n, .pin_pullup, .overflow_irq
);

//--- testbench/sus_bus_peer.sv
`timescale 1ns/1ps

module sus_bus_peer (
    input  wire logic scl,      // resolved clock wire
    output logic      scl_oe_n, // low while pulling clock
    output logic      sda_oe_n  // low while pulling data
);
    // both lines released between frames, clock stands still
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end

    // start, eight bits msb first, then release; half sets the speed
    task automatic send_byte(input logic [7:0] b, input int half);
        int n;
        // step off the bench clock edge so pin changes never race a sample
        #10;
        sda_oe_n = 1'b0;
        #(half);
        scl_oe_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #(half / 2);
            sda_oe_n = b[i];
            #(half / 2);
            scl_oe_n = 1'b1;
            n = 0;
            // a held clock stretches the bit, bounded
            while (scl !== 1'b1 && n < 2000) begin
                #20;
                n++;
            end
            #(half);
            scl_oe_n = 1'b0;
        end
        #(half);
        sda_oe_n = 1'b1;
        scl_oe_n = 1'b1;
    endtask
endmodule

//--- testbench/sus_unit_tb.sv
`timescale 1ns/1ps

module sus_unit_tb;
    import sus_pkg::*;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        global_irq_enable = 1'b0;
    logic        timer_compare_match = 1'b0;
    logic        tb_sda = 1'b1;
    logic [31:0] prdata, r, exp_d;
    logic [31:0] seed = 32'd35;
    logic        pready, pslverr, overflow_irq, start_irq, e;
    logic        scl_w, sda_w, peer_scl_oe_n, peer_sda_oe_n;
    sus_pins_t   pin_in, pin_out, pin_oe_n, pin_pullup;
    int          num_errors = 0;
    int          checks = 0;

    always #10 clock = ~clock;

    // open-drain wires, released lines float high
    assign scl_w  = (pin_oe_n.clk | pin_out.clk) & peer_scl_oe_n;
    assign sda_w  = (pin_oe_n.data | pin_out.data) & peer_sda_oe_n & tb_sda;
    assign pin_in = {scl_w, sda_w, pin_oe_n.dout | pin_out.dout};

    sus_unit i_dut (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .global_irq_enable, .timer_compare_match, .pin_in, .pin_out,
        .pin_oe_n, .pin_pullup, .overflow_irq, .start_irq
    );
    sus_bus_peer i_peer (.scl(scl_w), .scl_oe_n(peer_scl_oe_n), .sda_oe_n(peer_sda_oe_n));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // one left shift of the serial register
    function automatic logic [7:0] shl(input logic [7:0] v, input logic b);
        return {v[6:0], b};
    endfunction

    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, then one idle edge so the next never collides
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // answer taken at the rising edge that sees pready high
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        check(r & m, x);
    endtask

    // status polled until a flag shows, bounded
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(SUS_OFS_STAT, 1'b0, 32'h0);
            n++;
        end while (r[b] !== 1'b1 && n < 300);
        check(32'(r[b]), 32'h1);
        if (r[b] !== 1'b1) begin
            wrap_up();
        end
    endtask

    // bench side of a received frame: both clock holds and their release
    task automatic frame_side(input logic [7:0] b);
        int n;
        n = 0;
        while (scl_w !== 1'b0 && n < 500) begin
            @(posedge clock);
            n++;
        end
        if (scl_w !== 1'b0) begin
            num_errors++;
            wrap_up();
        end
        repeat (20) @(posedge clock);
        check(32'(scl_w), 32'h0);
        poll(7);
        check(32'(start_irq), 32'h1);
        apb(SUS_OFS_STAT, 1'b1, 32'h80);
        check(32'(start_irq), 32'h0);
        poll(6);
        repeat (20) @(posedge clock);
        check(32'(scl_w), 32'h0);
        rd(SUS_OFS_DATA, 32'hFF, 32'(b));
        rd(SUS_OFS_BUF, 32'hFF, 32'(b));
        repeat (4) @(posedge clock);
        check(32'(scl_w), 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // reset values, then an unmapped word
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), 32'hFFFFFFFF, 32'h0);
        end
        check(32'(e), 32'h1);
        check(32'(pin_oe_n), 32'h7);
        // software strobe shifts in the data level of the cycle before
        seed = xs(seed);
        exp_d = 32'(seed[7:0]);
        apb(SUS_OFS_DATA, 1'b1, exp_d);
        apb(SUS_OFS_CTRL, 1'b1, 32'h00);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            tb_sda <= seed[0];
            repeat (3) @(posedge clock);
            exp_d = 32'(shl(exp_d[7:0], seed[0]));
            apb(SUS_OFS_CTRL, 1'b1, 32'h02);
        end
        rd(SUS_OFS_DATA, 32'hFF, exp_d);
        rd(SUS_OFS_STAT, 32'hFF, 32'h40);
        rd(SUS_OFS_CTRL, 32'hFF, 32'h00);
        // a pending overflow is requested once both enables are set
        apb(SUS_OFS_CTRL, 1'b1, 32'h40);
        check(32'(overflow_irq), 32'h0);
        global_irq_enable <= 1'b1;
        @(negedge clock);
        check(32'(overflow_irq), 32'h1);
        @(posedge clock);
        tb_sda <= 1'b1;
        apb(SUS_OFS_STAT, 1'b1, 32'h40);
        check(32'(overflow_irq), 32'h0);
        // timer compare clocks shift and counter alike
        apb(SUS_OFS_CTRL, 1'b1, 32'h04);
        for (int i = 0; i < 3; i++) begin
            timer_compare_match <= 1'b1;
            @(posedge clock);
            timer_compare_match <= 1'b0;
            repeat (2) @(posedge clock);
        end
        rd(SUS_OFS_STAT, 32'hFF, 32'h03);
        rd(SUS_OFS_DATA, 32'hFF, 32'({exp_d[4:0], 3'h7}));
        // three-wire: shift msb replaces the data-out port bit at once
        apb(SUS_OFS_DIR, 1'b1, 32'h1);
        apb(SUS_OFS_CTRL, 1'b1, 32'h10);
        for (int i = 0; i < 2; i++) begin
            apb(SUS_OFS_DATA, 1'b1, 32'(8'h7F + i));
            check(32'(pin_out.dout), 32'(i));
        end
        // toggle strobe flips the clock port bit, counts when selected
        apb(SUS_OFS_CTRL, 1'b1, 32'h01);
        rd(SUS_OFS_PORT, 32'h7, 32'h4);
        apb(SUS_OFS_CTRL, 1'b1, 32'h0A);
        apb(SUS_OFS_STAT, 1'b1, 32'h0);
        repeat (3) apb(SUS_OFS_CTRL, 1'b1, 32'h0B);
        rd(SUS_OFS_STAT, 32'hF, 32'h3);
        rd(SUS_OFS_PORT, 32'h7, 32'h0);
        // two-wire data driver: low if shift msb or port bit is zero
        apb(SUS_OFS_DIR, 1'b1, 32'h6);
        apb(SUS_OFS_CTRL, 1'b1, 32'h20);
        for (int k = 0; k < 4; k++) begin
            apb(SUS_OFS_PORT, 1'b1, 32'(2 * (k % 2) + 4 * (k / 2)));
            apb(SUS_OFS_DATA, 1'b1, 32'(128 * (k / 2)));
            check(32'(pin_oe_n.data), 32'(k == 3));
            check(32'({pin_pullup.clk, pin_pullup.data}), 32'h0);
        end
        // slave receive of two random bytes; data driver off so sda is the peer's
        apb(SUS_OFS_DIR, 1'b1, 32'h4);
        apb(SUS_OFS_CTRL, 1'b1, 32'hB8);
        for (int f = 0; f < 2; f++) begin
            seed = xs(seed);
            apb(SUS_OFS_DATA, 1'b1, 32'hFF);
            apb(SUS_OFS_STAT, 1'b1, 32'hC0);
            fork
                i_peer.send_byte(seed[7:0], 80);
                frame_side(seed[7:0]);
            join
        end
        wrap_up();
    end
endmodule
